// file: include/poison_pkg.sv
package poison_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] HUB_LINK_OFFSET = 8'he4;
  localparam logic [ADDR_W-1:0] WRITE_BUFFER_OFFSET = 8'he8;
  localparam logic [ADDR_W-1:0] MEMORY_OFFSET = 8'hec;
  localparam int POISON_BIT = 18;
  localparam logic [DATA_W-1:0] ENABLE_MASK = 32'h0004_0000;
  localparam logic [DATA_W-1:0] HUB_LINK_RESET = 32'h0004_0000;
  localparam logic [DATA_W-1:0] WRITE_BUFFER_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MEMORY_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_VALUE = 32'h0000_0000;
  // Memory ECC modes; only 72-bit and single-device allow buffer and memory poisoning
  typedef enum logic [1:0] {
    ECC_NONE,
    ECC_72BIT,
    ECC_SINGLE_DEVICE,
    ECC_OTHER
  } ecc_mode_type;
endpackage

// file: hw/poison_stage.sv
`timescale 1ns/1ps
// One source path: tags or repairs data per the latched enable
module poison_stage #(
  parameter int WIDTH = 64
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic gateOk,
  input wire logic repairWhenOff,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inParityErr,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  output logic outPoison,
  output logic outParity
);
  // Register each beat with its handling decided on entry
  always_ff @(posedge clk) begin
    if (!resetn) begin
      outValid <= 1'b0;
      outData <= '0;
      outPoison <= 1'b0;
      outParity <= 1'b0;
    end else begin
      outValid <= inValid;
      outData <= inData;
      outPoison <= inValid && inParityErr && enable && gateOk;
      // Fresh good parity when errors are not passed on
      if (repairWhenOff && !(enable && gateOk))
        outParity <= ^inData;
      else
        outParity <= (^inData) ^ inParityErr;
    end
  end
endmodule

// file: hw/data_poison_control.sv
`timescale 1ns/1ps
// Functional notes
// [R1] Hub link enable set: parity-error hub data is marked poisoned.
// [R2] Hub link enable resets to one; other bits reserved.
// [R3] Hub link enable clear: no checking, no poison mark.
// [R4] Write buffer enable set poisons errors only in 72-bit or x4 ECC mode.
// [R5] Buffer or memory enable clear: regenerate correct parity instead.
// [R6] Memory enable set poisons errors only in 72-bit or x4 ECC mode.
// [R7] Buffer and memory registers reset to zero; only bit 18 writable.
// [R8] Enable changes apply to data after the write; in-flight data kept.
module data_poison_control
  import poison_pkg::*;
#(
  parameter int DATA_WIDTH = 64
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [poison_pkg::ADDR_W-1:0] cfgAddr,
  input wire logic [poison_pkg::DATA_W-1:0] cfgWriteData,
  output logic [poison_pkg::DATA_W-1:0] cfgReadData,
  input wire poison_pkg::ecc_mode_type eccMode,
  input wire logic hubValid,
  input wire logic [DATA_WIDTH-1:0] hubData,
  input wire logic hubParityErr,
  output logic hubOutValid,
  output logic [DATA_WIDTH-1:0] hubOutData,
  output logic hubOutPoison,
  output logic hubOutParity,
  input wire logic bufValid,
  input wire logic [DATA_WIDTH-1:0] bufData,
  input wire logic bufParityErr,
  output logic bufOutValid,
  output logic [DATA_WIDTH-1:0] bufOutData,
  output logic bufOutPoison,
  output logic bufOutParity,
  input wire logic memValid,
  input wire logic [DATA_WIDTH-1:0] memData,
  input wire logic memParityErr,
  output logic memOutValid,
  output logic [DATA_WIDTH-1:0] memOutData,
  output logic memOutPoison,
  output logic memOutParity
);
  import poison_pkg::*;

  logic [DATA_W-1:0] hubCtl_reg;
  logic [DATA_W-1:0] bufCtl_reg;
  logic [DATA_W-1:0] memCtl_reg;
  logic eccPoisonOk;

  // Writable field only; reserved bits stay at reset value
  function automatic logic [DATA_W-1:0] merge_enable(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] wdata
  );
    merge_enable = (old & ~ENABLE_MASK) | (wdata & ENABLE_MASK);
  endfunction

  // Hub link control register
  always_ff @(posedge clk) begin
    if (!resetn)
      hubCtl_reg <= HUB_LINK_RESET; // R2
    else if (cfgWrite && cfgAddr == HUB_LINK_OFFSET)
      hubCtl_reg <= merge_enable(hubCtl_reg, cfgWriteData); // R2
  end

  // Write buffer control register
  always_ff @(posedge clk) begin
    if (!resetn)
      bufCtl_reg <= WRITE_BUFFER_RESET; // R7
    else if (cfgWrite && cfgAddr == WRITE_BUFFER_OFFSET)
      bufCtl_reg <= merge_enable(bufCtl_reg, cfgWriteData); // R7
  end

  // Memory interface control register
  always_ff @(posedge clk) begin
    if (!resetn)
      memCtl_reg <= MEMORY_RESET; // R7
    else if (cfgWrite && cfgAddr == MEMORY_OFFSET)
      memCtl_reg <= merge_enable(memCtl_reg, cfgWriteData); // R7
  end

  // Registered read data; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!resetn)
      cfgReadData <= UNMAPPED_VALUE;
    else if (cfgRead) begin
      unique case (cfgAddr)
        HUB_LINK_OFFSET: cfgReadData <= hubCtl_reg;
        WRITE_BUFFER_OFFSET: cfgReadData <= bufCtl_reg;
        MEMORY_OFFSET: cfgReadData <= memCtl_reg;
        default: cfgReadData <= UNMAPPED_VALUE;
      endcase
    end
  end

  // ECC modes in which poisoning may apply
  assign eccPoisonOk = (eccMode == ECC_72BIT) ||
                       (eccMode == ECC_SINGLE_DEVICE); // R4 R6

  // Enables sampled at entry, so in-flight beats keep handling
  poison_stage #(.WIDTH(DATA_WIDTH)) hubStage ( // R1 R3 R8
    .clk(clk),
    .resetn(resetn),
    .enable(hubCtl_reg[POISON_BIT]),
    .gateOk(1'b1),
    .repairWhenOff(1'b1),
    .inValid(hubValid),
    .inData(hubData),
    .inParityErr(hubParityErr),
    .outValid(hubOutValid),
    .outData(hubOutData),
    .outPoison(hubOutPoison),
    .outParity(hubOutParity)
  );

  poison_stage #(.WIDTH(DATA_WIDTH)) bufStage ( // R4 R5 R8
    .clk(clk),
    .resetn(resetn),
    .enable(bufCtl_reg[POISON_BIT]),
    .gateOk(eccPoisonOk),
    .repairWhenOff(1'b1),
    .inValid(bufValid),
    .inData(bufData),
    .inParityErr(bufParityErr),
    .outValid(bufOutValid),
    .outData(bufOutData),
    .outPoison(bufOutPoison),
    .outParity(bufOutParity)
  );

  poison_stage #(.WIDTH(DATA_WIDTH)) memStage ( // R5 R6 R8
    .clk(clk),
    .resetn(resetn),
    .enable(memCtl_reg[POISON_BIT]),
    .gateOk(eccPoisonOk),
    .repairWhenOff(1'b1),
    .inValid(memValid),
    .inData(memData),
    .inParityErr(memParityErr),
    .outValid(memOutValid),
    .outData(memOutData),
    .outPoison(memOutPoison),
    .outParity(memOutParity)
  );

  // Hub link path: poison when enabled, fresh parity when not
  hub_poison_a: assert property (@(posedge clk) disable iff (!resetn) // R1
    hubValid && hubParityErr && hubCtl_reg[POISON_BIT]
    |=> hubOutPoison) else $error("hub error not poisoned");
  hub_off_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    !hubCtl_reg[POISON_BIT] |=> !hubOutPoison)
    else $error("hub poisoned while off");
  hub_repair_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    hubValid && !hubCtl_reg[POISON_BIT]
    |=> hubOutParity == ^hubOutData)
    else $error("hub parity not regenerated");

  // Buffer and memory paths: ECC mode gate and parity repair
  buf_poison_a: assert property (@(posedge clk) disable iff (!resetn) // R4
    bufValid && bufParityErr && bufCtl_reg[POISON_BIT] && eccPoisonOk
    |=> bufOutPoison) else $error("buffer error not poisoned");
  buf_gate_a: assert property (@(posedge clk) disable iff (!resetn) // R4 R6
    !eccPoisonOk |=> !bufOutPoison && !memOutPoison)
    else $error("poison outside ECC mode");
  buf_repair_a: assert property (@(posedge clk) disable iff (!resetn) // R5
    bufValid && !bufCtl_reg[POISON_BIT]
    |=> !bufOutPoison && bufOutParity == ^bufOutData)
    else $error("buffer parity not repaired");
  mem_repair_a: assert property (@(posedge clk) disable iff (!resetn) // R5
    memValid && !memCtl_reg[POISON_BIT]
    |=> !memOutPoison && memOutParity == ^memOutData)
    else $error("memory parity not repaired");
  mem_poison_a: assert property (@(posedge clk) disable iff (!resetn) // R6
    memValid && memParityErr && memCtl_reg[POISON_BIT] && eccPoisonOk
    |=> memOutPoison) else $error("memory error not poisoned");

  // Register reset values, reserved bits and read path
  hub_reset_a: assert property (@(posedge clk) // R2
    !resetn |=> hubCtl_reg == HUB_LINK_RESET)
    else $error("hub reset value wrong");
  buf_reset_a: assert property (@(posedge clk) // R7
    !resetn |=> bufCtl_reg == WRITE_BUFFER_RESET &&
    memCtl_reg == MEMORY_RESET)
    else $error("buffer or memory reset value wrong");
  hub_reserved_a: assert property (@(posedge clk) disable iff (!resetn) // R2
    (hubCtl_reg & ~ENABLE_MASK) == '0)
    else $error("hub reserved bits changed");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn) // R7
    ((bufCtl_reg | memCtl_reg) & ~ENABLE_MASK) == '0)
    else $error("reserved bits changed");
  read_hub_a: assert property (@(posedge clk) disable iff (!resetn) // R2
    cfgRead && cfgAddr == HUB_LINK_OFFSET
    |=> cfgReadData == $past(hubCtl_reg))
    else $error("hub read data wrong");
  buf_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R7
    !(cfgWrite && cfgAddr == WRITE_BUFFER_OFFSET)
    |=> $stable(bufCtl_reg))
    else $error("buffer register changed without write");
  mem_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R7
    !(cfgWrite && cfgAddr == MEMORY_OFFSET)
    |=> $stable(memCtl_reg))
    else $error("memory register changed without write");

  // Beat entering on the write edge keeps the old enable
  enable_timing_a: assert property (@(posedge clk) disable iff (!resetn) // R8
    cfgWrite && cfgAddr == HUB_LINK_OFFSET && hubValid && hubParityErr
    |=> hubOutPoison == $past(hubCtl_reg[POISON_BIT]))
    else $error("enable reached old data");

  // Main scenarios reached
  hub_poison_c: cover property (@(posedge clk) disable iff (!resetn)
    hubOutPoison);
  buf_poison_c: cover property (@(posedge clk) disable iff (!resetn)
    bufOutPoison);
  mem_poison_c: cover property (@(posedge clk) disable iff (!resetn)
    memOutPoison);
  mem_repair_c: cover property (@(posedge clk) disable iff (!resetn)
    memValid && memParityErr && !memCtl_reg[POISON_BIT]);
  enable_write_c: cover property (@(posedge clk) disable iff (!resetn)
    cfgWrite && cfgAddr == HUB_LINK_OFFSET && hubValid && hubParityErr);
endmodule

// file: testbench/data_poison_control_bench.sv
`timescale 1ns/1ps
module data_poison_control_bench;
  import poison_pkg::*;
  logic clk, resetn, cfgWrite, cfgRead;
  logic [ADDR_W-1:0] cfgAddr;
  logic [DATA_W-1:0] cfgWriteData, cfgReadData;
  ecc_mode_type eccMode;
  logic hubValid, hubParityErr, hubOutValid, hubOutPoison, hubOutParity;
  logic bufValid, bufParityErr, bufOutValid, bufOutPoison, bufOutParity;
  logic memValid, memParityErr, memOutValid, memOutPoison, memOutParity;
  logic [63:0] hubData, bufData, memData, hubOutData, bufOutData, memOutData;
  int mismatches, total_checks, cycles;
  logic ok;

  data_poison_control #(.DATA_WIDTH(64)) dut_u (
    .clk(clk), .resetn(resetn), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgAddr(cfgAddr), .cfgWriteData(cfgWriteData),
    .cfgReadData(cfgReadData), .eccMode(eccMode),
    .hubValid(hubValid), .hubData(hubData), .hubParityErr(hubParityErr),
    .hubOutValid(hubOutValid), .hubOutData(hubOutData),
    .hubOutPoison(hubOutPoison), .hubOutParity(hubOutParity),
    .bufValid(bufValid), .bufData(bufData), .bufParityErr(bufParityErr),
    .bufOutValid(bufOutValid), .bufOutData(bufOutData),
    .bufOutPoison(bufOutPoison), .bufOutParity(bufOutParity),
    .memValid(memValid), .memData(memData), .memParityErr(memParityErr),
    .memOutValid(memOutValid), .memOutData(memOutData),
    .memOutPoison(memOutPoison), .memOutParity(memOutParity)
  );

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end

  task check(input string name, input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgWriteData <= d;
    @(posedge clk);
    cfgWrite <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRead <= 1'b0;
    #1;
    check("cfgReadData", {32'h0, cfgReadData}, {32'h0, exp});
  endtask

  // One beat on all sources; p is expected poison, cp selects parity checks
  task beat(input logic [63:0] d, input logic err, input logic [2:0] p, cp);
    @(posedge clk);
    {hubValid, bufValid, memValid} <= 3'b111;
    {hubData, bufData, memData} <= {d, ~d, d};
    {hubParityErr, bufParityErr, memParityErr} <= {3{err}};
    @(posedge clk);
    {hubValid, bufValid, memValid} <= 3'b000;
    #1;
    check("outValid", {hubOutValid, bufOutValid, memOutValid}, 3'b111);
    check("outData", hubOutData ^ bufOutData ^ memOutData, ~d);
    check("outPoison", {hubOutPoison, bufOutPoison, memOutPoison}, p);
    check("outParity", {hubOutParity, bufOutParity, memOutParity} & cp,
      ({^d, ^(~d), ^d} ^ p) & cp);
  endtask

  task final_report();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {resetn, cfgWrite, cfgRead, hubValid, bufValid, memValid} = 6'h0;
    {hubParityErr, bufParityErr, memParityErr} = 3'h0;
    {cfgAddr, cfgWriteData, hubData, bufData, memData} = '0;
    eccMode = ECC_72BIT;
    {mismatches, total_checks, cycles} = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(8'he4, 32'h0004_0000);
    rd(8'he8, 32'h0000_0000);
    rd(8'hec, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    beat(64'h0123_4567_89ab_cdef, 1'b1, 3'b100, 3'b111);
    beat(64'h0000_0000_0000_0001, 1'b0, 3'b000, 3'b111);
    wr(8'he8, 32'hffff_ffff);
    wr(8'hec, 32'h0004_0000);
    rd(8'he8, 32'h0004_0000);
    rd(8'hec, 32'h0004_0000);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      eccMode <= ecc_mode_type'(m);
      ok = (m == 1) || (m == 2);
      beat(64'hf0f0_0000_0000_0007, 1'b1, {2'b10, ok} | {1'b0, ok, 1'b0},
        {1'b1, ok, ok});
    end
    // Back to a poisoning ECC mode for the later beats
    @(posedge clk);
    eccMode <= ECC_72BIT;
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0000_0000);
    // Beat on the write edge keeps the old enable, next beat sees the new
    @(posedge clk);
    cfgWrite <= 1'b1;
    cfgAddr <= 8'he4;
    cfgWriteData <= 32'h0000_0000;
    {hubValid, hubParityErr, hubData} <= {2'b11, 64'h3};
    @(posedge clk);
    cfgWrite <= 1'b0;
    #1;
    check("hubOutPoison", hubOutPoison, 1'b1);
    @(posedge clk);
    hubValid <= 1'b0;
    #1;
    check("hubOutPoison", hubOutPoison, 1'b0);
    rd(8'he4, 32'h0000_0000);
    beat(64'h0000_0000_0000_0003, 1'b1, 3'b011, 3'b111);
    // Mid-run reset restores the default enables
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    rd(8'he4, 32'h0004_0000);
    rd(8'he8, 32'h0000_0000);
    rd(8'hec, 32'h0000_0000);
    final_report();
  end
endmodule
